// File: design/idd_pkg.sv
// Package: register map, field layout and reset values of the ID detector register slice
package idd_pkg;
  localparam int unsigned idd_addr_w = 8;
  // Register indices; the bus sees one aligned word each, at four times the index
  localparam logic [5:0] idd_idx_flags = 6'h03;
  localparam logic [5:0] idd_idx_mask = 6'h04;
  localparam logic [5:0] idd_idx_isrc = 6'h06;
  localparam logic [5:0] idd_idx_mode = 6'h10;
  localparam logic [7:0] idd_off_flags = {idd_idx_flags, 2'b00};
  localparam logic [7:0] idd_off_mask = {idd_idx_mask, 2'b00};
  localparam logic [7:0] idd_off_isrc = {idd_idx_isrc, 2'b00};
  localparam logic [7:0] idd_off_mode = {idd_idx_mode, 2'b00};
  localparam int unsigned idd_byte_w = 8;
  localparam int unsigned idd_cur_w = 3;
  localparam int unsigned idd_mode_bit = 0;
  localparam logic [7:0] idd_flags_rst = 8'h00;
  localparam logic [7:0] idd_mask_rst = 8'hff;
  localparam logic [2:0] idd_setting_rst = 3'h3;
  localparam logic [2:0] idd_cur_off = 3'h0;
  localparam logic [2:0] idd_cur_reserved = 3'h7;
  localparam int unsigned idd_mon_lsb = 4;
  localparam int unsigned idd_set_lsb = 0;
  localparam int unsigned idd_num_src = 8;
  localparam int unsigned idd_bit_above = 7;
  localparam int unsigned idd_bit_zc = 6;
  localparam int unsigned idd_bit_eoc = 5;
  localparam int unsigned idd_bit_timer = 4;
  localparam int unsigned idd_bit_acc = 3;
  localparam int unsigned idd_bit_therm = 2;
  localparam int unsigned idd_bit_idov = 1;
  localparam int unsigned idd_bit_enpin = 0;
endpackage

// File: design/idd_regs.sv
// Interrupt flag, mask and current source registers of the ID detector, APB slave
//
// Contract
// - Reading the flag register clears all its bits except those with an event in that cycle, so each read shows events since the last.
// - A flag bit latches 1 on its event while clk_en is high; bit 7 above-threshold down to bit 0 enable-pin change.
// - All eight flag bits reset to 0, meaning no event has occurred.
// - The mask register is read/write, same bit order, 1 masks a source, and resets to all ones.
// - Bits 6:4 of the current source register read back the applied detection current code.
// - Manual mode applies the setting in bits 2:0; auto mode uses it as an upper limit.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps

module idd_regs
  import idd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [idd_addr_w-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic input_above_threshold_flag,
  input wire logic zero_crossing_flag,
  input wire logic conversion_done_flag,
  input wire logic timer_period_expired_flag,
  input wire logic accessory_detect_flag,
  input wire logic thermal_shutdown_flag,
  input wire logic id_overvoltage_flag,
  input wire logic enable_pin_change_flag,
  input wire logic [2:0] auto_current_request,
  output logic [2:0] applied_current,
  output logic irq
);

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic access;
  logic wr;
  logic rd;
  logic hit_flags;
  logic hit_mask;
  logic hit_isrc;
  logic hit_mode;
  logic mapped;

  assign access = psel && penable && clk_en;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign mapped = hit_flags || hit_mask || hit_isrc || hit_mode;

  // Only the four word-aligned register offsets decode; anything else answers with an error
  always_comb
  begin
    hit_flags = 1'b0;
    hit_mask = 1'b0;
    hit_isrc = 1'b0;
    hit_mode = 1'b0;
    case (paddr)
      idd_off_flags: hit_flags = 1'b1;
      idd_off_mask: hit_mask = 1'b1;
      idd_off_isrc: hit_isrc = 1'b1;
      idd_off_mode: hit_mode = 1'b1;
      default: hit_flags = 1'b0;
    endcase
  end
  // Zero wait states; pready follows clk_en, so a frozen clock enable holds the transfer until the next enabled edge
  assign pready = clk_en;
  assign pslverr = !mapped;

  // ------------------------------------------------------------
  // Flags
  // ------------------------------------------------------------
  logic [7:0] flags;
  logic [7:0] events;
  logic [7:0] mask;
  logic [7:0] wr_byte;
  logic read_clear;
  logic mask_load;

  // ------------------------------------------------------------
  // Write and clear strobes
  // ------------------------------------------------------------
  assign read_clear = rd && hit_flags;
  assign mask_load = wr && hit_mask;
  assign wr_byte = pwdata[idd_byte_w-1:0];

  always_comb
  begin
    events = '0;
    events[idd_bit_above] = input_above_threshold_flag;
    events[idd_bit_zc] = zero_crossing_flag;
    events[idd_bit_eoc] = conversion_done_flag;
    events[idd_bit_timer] = timer_period_expired_flag;
    events[idd_bit_acc] = accessory_detect_flag;
    events[idd_bit_therm] = thermal_shutdown_flag;
    events[idd_bit_idov] = id_overvoltage_flag;
    events[idd_bit_enpin] = enable_pin_change_flag;
  end

  // ------------------------------------------------------------
  // Flag and mask bits, one slice per source
  // ------------------------------------------------------------
  // Event set wins over the read clear so nothing arriving during the read is lost
  genvar gi;
  generate
    for (gi = 0; gi < idd_num_src; gi++)
    begin : g_src
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          flags[gi] <= idd_flags_rst[gi];
        end
        else if (clk_en)
        begin
          if (events[gi])
          begin
            flags[gi] <= 1'b1;
          end
          else if (read_clear)
          begin
            flags[gi] <= 1'b0;
          end
        end
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          mask[gi] <= idd_mask_rst[gi];
        end
        else if (mask_load)
        begin
          mask[gi] <= wr_byte[gi];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Current source setting and mode
  // ------------------------------------------------------------
  logic [2:0] setting;
  logic auto_mode;
  logic setting_load;
  logic mode_load;
  logic [2:0] wr_setting;
  logic wr_mode;
  logic [2:0] clipped_request;
  logic [2:0] next_applied;

  assign setting_load = wr && hit_isrc;
  assign mode_load = wr && hit_mode;
  assign wr_setting = pwdata[idd_set_lsb +: idd_cur_w];
  assign wr_mode = pwdata[idd_mode_bit];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      setting <= idd_setting_rst;
    end
    else if (setting_load)
    begin
      setting <= wr_setting;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      auto_mode <= 1'b0;
    end
    else if (mode_load)
    begin
      auto_mode <= wr_mode;
    end
  end

  // ------------------------------------------------------------
  // Applied current
  // ------------------------------------------------------------
  // Auto requests above the limit are clipped, i.e. the higher steps are skipped
  always_comb
  begin
    if (auto_current_request > setting)
    begin
      clipped_request = setting;
    end
    else
    begin
      clipped_request = auto_current_request;
    end
  end

  // Reserved code never reaches the source; it falls back to off
  always_comb
  begin
    next_applied = setting;
    if (auto_mode)
    begin
      next_applied = clipped_request;
    end
    if (next_applied == idd_cur_reserved)
    begin
      next_applied = idd_cur_off;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      applied_current <= idd_cur_off;
    end
    else if (clk_en)
    begin
      applied_current <= next_applied;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [31:0] next_rdata;
  logic [7:0] isrc_word;
  logic rd_setup;

  assign rd_setup = clk_en && psel && !penable && !pwrite;

  always_comb
  begin
    isrc_word = '0;
    isrc_word[idd_mon_lsb +: idd_cur_w] = applied_current;
    isrc_word[idd_set_lsb +: idd_cur_w] = setting;
  end

  // Flags are taken at setup together with this cycle's events so none is lost
  always_comb
  begin
    next_rdata = '0;
    unique case (1'b1)
      hit_flags: next_rdata[idd_byte_w-1:0] = flags | events;
      hit_mask: next_rdata[idd_byte_w-1:0] = mask;
      hit_isrc: next_rdata[idd_byte_w-1:0] = isrc_word;
      hit_mode: next_rdata[idd_mode_bit] = auto_mode;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
    end
    else if (rd_setup)
    begin
      prdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // Interrupt
  // ------------------------------------------------------------
  logic [7:0] pending;

  assign pending = flags & ~mask;
  assign irq = |pending;

endmodule

// File: testbench/idd_regs_props.sv
// Assertion checker for the ID detector register slice
`timescale 1ns/1ps
module idd_regs_props
  import idd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [idd_addr_w-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic input_above_threshold_flag,
  input wire logic zero_crossing_flag,
  input wire logic conversion_done_flag,
  input wire logic timer_period_expired_flag,
  input wire logic accessory_detect_flag,
  input wire logic thermal_shutdown_flag,
  input wire logic id_overvoltage_flag,
  input wire logic enable_pin_change_flag,
  input wire logic [2:0] applied_current,
  input wire logic irq
);
  wire logic [7:0] ev = {input_above_threshold_flag, zero_crossing_flag, conversion_done_flag,
    timer_period_expired_flag, accessory_detect_flag, thermal_shutdown_flag,
    id_overvoltage_flag, enable_pin_change_flag};
  wire logic mapped = paddr inside {idd_off_flags, idd_off_mask, idd_off_isrc, idd_off_mode};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_rd(a);
    psel && !penable && !pwrite && clk_en && paddr == a;
  endsequence
  sequence acc_rd(a);
    psel && penable && !pwrite && clk_en && paddr == a;
  endsequence
  read_clears_flags_a: assert property (acc_rd(idd_off_flags) ##0 ev == 8'h00 |=> !irq)
    else $error("irq up after flag read");
  event_latched_a: assert property (setup_rd(idd_off_flags) |=>
    (prdata[7:0] & $past(ev)) == $past(ev)) else $error("event missing in flags");
  irq_cause_a: assert property ($rose(irq) |-> $past(ev != 8'h00 || (psel && pwrite)))
    else $error("irq rose without cause");
  monitor_read_a: assert property (setup_rd(idd_off_isrc) |=> prdata[6:4] ==
    $past(applied_current) && prdata[7] == 1'b0 && prdata[3] == 1'b0) else $error("bad monitor");
  no_reserved_a: assert property (applied_current != idd_cur_reserved)
    else $error("reserved current applied");
  unmapped_err_a: assert property (psel && penable && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  upper_zero_a: assert property (setup_rd(paddr) |=> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
endmodule
bind idd_regs idd_regs_props u_idd_regs_props (.*);

// File: testbench/id_detector_irq_and_source_regs_tb_top.sv
// Testbench of the ID detector register slice
`timescale 1ns/1ps
module id_detector_irq_and_source_regs_tb_top
  import idd_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clk_en = 1;
  logic [7:0] paddr = 0, ev = 0, m, r;
  logic [31:0] pwdata = 0, prdata, q[$];
  logic pready, pslverr, irq;
  logic [2:0] auto_current_request = 0, applied_current, t;
  int err_total = 0, cmp_count = 0, cyc = 0;
  idd_regs u_idd_regs (.*, .input_above_threshold_flag(ev[7]), .zero_crossing_flag(ev[6]),
    .conversion_done_flag(ev[5]), .timer_period_expired_flag(ev[4]),
    .accessory_detect_flag(ev[3]), .thermal_shutdown_flag(ev[2]),
    .id_overvoltage_flag(ev[1]), .enable_pin_change_flag(ev[0]));
  always #2 pclk = ~pclk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Master holds the request until pready; the idle edge lets applied settle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(0, a, 0);
  endtask
  task automatic irq_is(input logic e);
    @(negedge pclk);
    chk(irq, e, "irq");
    @(posedge pclk);
  endtask
  task automatic pulse(input logic [7:0] v);
    ev <= v;
    @(posedge pclk);
    ev <= 0;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (psel && penable && pready && !pwrite)
      chk(prdata, q.pop_front(), "prdata");
    if (psel && penable && pready)
      chk(pslverr, !(paddr inside {idd_off_flags, idd_off_mask, idd_off_isrc,
        idd_off_mode}), "pslverr");
    if (cyc == 4000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  initial
  begin
    void'($urandom(32'hdf09));
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(idd_off_flags, 0);
    rd(idd_off_mask, 32'hff);
    for (int i = 0; i < 8; i++)
    begin
      pulse(8'h01 << i);
      rd(idd_off_flags, 32'h1 << i);
      rd(idd_off_flags, 0);
    end
    irq_is(0);
    m = $urandom & 8'h7f;
    r = $urandom | 8'h80;
    apb(1, idd_off_mask, m);
    rd(idd_off_mask, m);
    pulse(m);
    irq_is(0);
    pulse(r);
    irq_is(1);
    rd(idd_off_flags, r | m);
    irq_is(0);
    // Clock enable low freezes the flags, so an event then is dropped
    clk_en <= 0;
    pulse(8'h80);
    irq_is(0);
    clk_en <= 1;
    rd(idd_off_flags, 0);
    // Setting 7 is reserved and must never reach the monitor
    for (int s = 0; s < 8; s++)
    begin
      apb(1, idd_off_isrc, 8'h70 | s);
      rd(idd_off_isrc, (s == 7 ? 0 : s << 4) | s);
      chk(applied_current, (s == 7 ? 0 : s), "applied");
    end
    apb(1, idd_off_mode, 1);
    repeat (6)
    begin
      t = $urandom % 7;
      r = $urandom % 7;
      auto_current_request <= t;
      apb(1, idd_off_isrc, r);
      rd(idd_off_isrc, ((t < r[2:0] ? t : r[2:0]) << 4) | r);
      chk(applied_current, (t < r[2:0] ? t : r[2:0]), "applied");
    end
    apb(1, 8'h20, 32'hff);
    rd(8'h20, 0);
    tally_and_finish();
  end
endmodule
